//--- rtl/shf_map.svh
// Register offsets, field positions, reset values and sizes of the shared queue
`ifndef SHF_MAP_SVH
`define SHF_MAP_SVH

// Register indices; byte address is four times the index
`define SHF_IDX_DATA 6'h02
`define SHF_IDX_STATUS 6'h03
`define SHF_IDX_FILL 6'h04
`define SHF_IDX_IEN 6'h06
`define SHF_IDX_IREQ 6'h07
`define SHF_IDX_CTRL 6'h09
`define SHF_IDX_ERR 6'h0a
`define SHF_IDX_THR 6'h29

// Field positions
`define SHF_BIT_NEAR_EMPTY 0
`define SHF_BIT_NEAR_FULL 1
`define SHF_BIT_IRQ 3
`define SHF_BIT_OVERRUN 4
`define SHF_BIT_PURGE 0
`define SHF_BIT_SET_CLEAR 7

// Sizes and reset values
`define SHF_DEPTH 64
`define SHF_WIDTH 8
`define SHF_THR_RESET 6'h08

`endif

//--- rtl/shf_pkg.sv
// Types shared by the shared queue modules
package shf_pkg;
   typedef logic [7:0] shf_byte_t;
   typedef logic [6:0] shf_count_t;
   typedef logic [5:0] shf_thr_t;
   typedef enum logic {SHF_BUS_IDLE, SHF_BUS_DONE} shf_bus_state_t;
endpackage : shf_pkg

//--- rtl/shf_queue_if.sv
// Connection between queue control and queue storage
`timescale 1ns/10ps
`default_nettype none
interface shf_queue_if;
   import shf_pkg::*;
   logic push;
   shf_byte_t push_data;
   logic pop;
   shf_byte_t pop_data;
   logic purge;
   shf_count_t count;
   logic full;
   logic empty;
   modport ctl (output push, output push_data, output pop, output purge,
      input pop_data, input count, input full, input empty);
   modport mem (input push, input push_data, input pop, input purge,
      output pop_data, output count, output full, output empty);
endinterface : shf_queue_if
`default_nettype wire

//--- rtl/shf_store.sv
// Byte storage with read and write pointers and fill count
`timescale 1ns/10ps
`default_nettype none
module shf_store #(
   parameter int DEPTH = 64,
   parameter int AW = 6
) (
   input wire logic clk,
   input wire logic rst_b,
   shf_queue_if.mem q
);
   import shf_pkg::*;

   shf_byte_t mem_reg [DEPTH];
   logic [AW-1:0] wr_ptr_reg;
   logic [AW-1:0] rd_ptr_reg;
   shf_count_t count_reg;
   wire do_push;
   wire do_pop;

   // Full queue refuses push, empty queue refuses pop
   assign do_push = q.push && !q.full && !q.purge;
   assign do_pop = q.pop && !q.empty && !q.purge;
   assign q.pop_data = mem_reg[rd_ptr_reg];
   assign q.count = count_reg;
   assign q.full = (count_reg == 7'(DEPTH));
   assign q.empty = (count_reg == 7'h00);

   always_ff @(posedge clk) begin
      if (do_push) begin
         mem_reg[wr_ptr_reg] <= q.push_data;
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         wr_ptr_reg <= '0;
         rd_ptr_reg <= '0;
         count_reg <= 7'h00;
      end else if (q.purge) begin
         wr_ptr_reg <= '0;
         rd_ptr_reg <= '0;
         count_reg <= 7'h00;
      end else begin
         if (do_push) begin
            wr_ptr_reg <= wr_ptr_reg + 1'b1;
         end
         if (do_pop) begin
            rd_ptr_reg <= rd_ptr_reg + 1'b1;
         end
         count_reg <= count_reg + 7'(do_push) - 7'(do_pop);
      end
   end
endmodule : shf_store
`default_nettype wire

//--- rtl/shf_queue_top.sv
// Shared host queue with warnings, interrupt flags and Avalon-MM register slave
//
// Chosen here: the Avalon-MM slave port.
`timescale 1ns/10ps
`default_nettype none
`include "shf_map.svh"

// Notes on behaviour
// - One 64 by 8 queue, both directions
// - Host data write stores, advances write pointer
// - Host data read returns byte, advances pointer
// - Fill count is its own up/down counter, 7 bits
// - Engines share the queue during commands
// - Purge clears pointers, count, overrun
// - Overrun flag at error bit 4
// - Near full when 64 minus count within threshold
// - Near empty when count within threshold
// - Warnings in status bits 1,0; count register
// - Interrupt pin when request meets enable
// - Summary status bit and pin signal interrupts
// - Requests set while matching warning high
// - Summary is OR of enabled requests
// - Bit 7 selects set or clear
// - Threshold resets to eight
module shf_queue_top #(
   parameter int DEPTH = `SHF_DEPTH
) (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic [7:0] address,
   input wire logic read,
   input wire logic write,
   input wire logic [31:0] writedata,
   input wire logic [3:0] byteenable,
   output logic [31:0] readdata,
   output logic waitrequest,
   input wire logic eng_push,
   input wire shf_pkg::shf_byte_t eng_push_data,
   input wire logic eng_pop,
   output shf_pkg::shf_byte_t eng_pop_data,
   output logic eng_ack,
   output shf_pkg::shf_count_t eng_fill,
   output logic host_irq
);
   import shf_pkg::*;

   function automatic logic [1:0] sc_apply(input logic [1:0] old, input logic [7:0] wd);
      sc_apply = wd[`SHF_BIT_SET_CLEAR] ? (old | wd[1:0]) : (old & ~wd[1:0]);
   endfunction : sc_apply

   shf_queue_if q ();

   shf_store #(
      .DEPTH(DEPTH),
      .AW($clog2(DEPTH))
   ) u_store (
      .clk(clk),
      .rst_b(rst_b),
      .q(q)
   );

   shf_bus_state_t bus_state_reg;
   shf_bus_state_t bus_state_next;
   logic waitrequest_reg;
   logic [31:0] readdata_reg;
   logic [1:0] ien_reg;
   logic [1:0] ireq_reg;
   logic overrun_reg;
   shf_thr_t thr_reg;
   logic irq_reg;
   shf_byte_t eng_pop_data_reg;
   logic eng_ack_reg;
   shf_count_t eng_fill_reg;

   wire [5:0] idx;
   wire req;
   wire accept;
   wire wr_acc;
   wire rd_acc;
   wire lane0;
   wire [7:0] wbyte;
   wire host_push;
   wire host_pop;
   wire host_busy;
   wire eng_take;
   wire purge;
   wire near_full;
   wire near_empty;
   wire [6:0] space;
   wire irq_sum;
   wire [1:0] warn;
   wire [1:0] ireq_sw;
   wire [1:0] ien_sw;
   wire [1:0] ireq_next;
   wire overrun_hit;
   wire [7:0] rd_byte;

   // Bus decode, request taken on the waiting cycle
   assign idx = address[7:2];
   assign req = read || write;
   assign accept = req && (bus_state_reg == SHF_BUS_IDLE);
   assign wr_acc = accept && write;
   assign rd_acc = accept && read;
   assign lane0 = byteenable[0];
   assign wbyte = writedata[7:0];

   always_comb begin
      bus_state_next = bus_state_reg;
      unique case (bus_state_reg)
         SHF_BUS_IDLE: begin
            if (req) begin
               bus_state_next = SHF_BUS_DONE;
            end
         end
         SHF_BUS_DONE: begin
            bus_state_next = SHF_BUS_IDLE;
         end
      endcase
   end

   assign host_push = wr_acc && lane0 && (idx == `SHF_IDX_DATA);
   assign host_pop = rd_acc && (idx == `SHF_IDX_DATA);
   assign purge = wr_acc && lane0 && (idx == `SHF_IDX_CTRL) && wbyte[`SHF_BIT_PURGE];
   assign host_busy = host_push || host_pop || purge;

   // Engines use the queue when host is not
   assign eng_take = (eng_push || eng_pop) && !host_busy;
   assign q.push = host_push || (eng_take && eng_push);
   assign q.push_data = host_push ? wbyte : eng_push_data;
   assign q.pop = host_pop || (eng_take && eng_pop);
   assign q.purge = purge;

   // Push into full queue flags overrun
   assign overrun_hit = q.push && q.full;

   assign space = 7'(DEPTH) - q.count;
   assign near_full = (space <= {1'b0, thr_reg});
   assign near_empty = (q.count <= {1'b0, thr_reg});
   assign warn = {near_full, near_empty};

   // Set or clear only written bits
   assign ireq_sw = (wr_acc && lane0 && idx == `SHF_IDX_IREQ) ? sc_apply(ireq_reg, wbyte) : ireq_reg;
   assign ien_sw = (wr_acc && lane0 && idx == `SHF_IDX_IEN) ? sc_apply(ien_reg, wbyte) : ien_reg;
   assign ireq_next = ireq_sw | warn;

   assign irq_sum = |(ireq_reg & ien_reg);

   assign rd_byte =
      (idx == `SHF_IDX_DATA) ? q.pop_data :
      (idx == `SHF_IDX_STATUS) ? {4'h0, irq_reg, 1'b0, near_full, near_empty} :
      (idx == `SHF_IDX_FILL) ? {1'b0, q.count} :
      (idx == `SHF_IDX_IEN) ? {6'h00, ien_reg} :
      (idx == `SHF_IDX_IREQ) ? {6'h00, ireq_reg} :
      (idx == `SHF_IDX_ERR) ? {3'h0, overrun_reg, 4'h0} :
      (idx == `SHF_IDX_THR) ? {2'h0, thr_reg} :
      8'h00;

   // Bus handshake and read capture
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         bus_state_reg <= SHF_BUS_IDLE;
         waitrequest_reg <= 1'b1;
         readdata_reg <= 32'h0000_0000;
      end else begin
         bus_state_reg <= bus_state_next;
         waitrequest_reg <= !accept;
         if (rd_acc) begin
            readdata_reg <= {24'h00_0000, (host_pop && q.empty) ? 8'h00 : rd_byte};
         end
      end
   end

   // Interrupt request and enable flags
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         ireq_reg <= 2'h0;
         ien_reg <= 2'h0;
      end else begin
         ireq_reg <= ireq_next;
         ien_reg <= ien_sw;
      end
   end

   // Overrun flag and threshold
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         overrun_reg <= 1'b0;
         thr_reg <= `SHF_THR_RESET;
      end else begin
         if (purge) begin
            overrun_reg <= 1'b0;
         end else if (overrun_hit) begin
            overrun_reg <= 1'b1;
         end
         if (wr_acc && lane0 && idx == `SHF_IDX_THR) begin
            thr_reg <= wbyte[5:0];
         end
      end
   end

   // Interrupt pin and engine side outputs
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         irq_reg <= 1'b0;
         eng_pop_data_reg <= 8'h00;
         eng_ack_reg <= 1'b0;
         eng_fill_reg <= 7'h00;
      end else begin
         irq_reg <= irq_sum;
         if (eng_take && eng_pop) begin
            eng_pop_data_reg <= q.pop_data;
         end
         eng_ack_reg <= eng_take;
         eng_fill_reg <= q.count;
      end
   end

   assign readdata = readdata_reg;
   assign waitrequest = waitrequest_reg;
   assign eng_pop_data = eng_pop_data_reg;
   assign eng_ack = eng_ack_reg;
   assign eng_fill = eng_fill_reg;
   // Summary bit and pin share one flop
   assign host_irq = irq_reg;
endmodule : shf_queue_top
`default_nettype wire

//--- verif/shf_queue_assertions.sv
// Port checker for the shared queue top
`timescale 1ns/10ps
`default_nettype none
module shf_queue_chk #(
   parameter int DEPTH = 64
) (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic [7:0] address,
   input wire logic read,
   input wire logic write,
   input wire logic [3:0] byteenable,
   input wire logic [31:0] readdata,
   input wire logic waitrequest,
   input wire logic eng_push,
   input wire logic eng_pop,
   input wire logic eng_ack,
   input wire shf_pkg::shf_count_t eng_fill
);
   import shf_pkg::*;
   wire logic take = waitrequest && (read || write);
   wire logic data_use = take && address[7:2] == 6'h02 && (read || byteenable[0]);
   wire logic ctl_wr = take && write && address[7:2] == 6'h09;
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);
   sequence s_taken; take; endsequence
   sequence s_done; !waitrequest ##1 waitrequest; endsequence
   property p_answer; s_taken |=> s_done; endproperty
   a_answer: assert property (p_answer) else $error("bus request not answered");
   property p_cause; $fell(waitrequest) |-> $past(take); endproperty
   a_cause: assert property (p_cause) else $error("answer without request");
   property p_eng_ack; (eng_push || eng_pop) && !data_use && !ctl_wr |=> eng_ack; endproperty
   a_eng_ack: assert property (p_eng_ack) else $error("engine op not acknowledged");
   property p_ack_cause; eng_ack |-> $past(eng_push || eng_pop); endproperty
   a_ack_cause: assert property (p_ack_cause) else $error("stray engine ack");
   property p_refuse; data_use |=> !eng_ack; endproperty
   a_refuse: assert property (p_refuse) else $error("engine taken during host access");
   property p_fill_step;
      !$stable(eng_fill) && eng_fill != 7'h00 |->
         eng_fill == $past(eng_fill) + 7'h01 || eng_fill == $past(eng_fill) - 7'h01;
   endproperty
   a_fill_step: assert property (p_fill_step) else $error("fill count jumped");
   property p_fill_max; eng_fill <= DEPTH; endproperty
   a_fill_max: assert property (p_fill_max) else $error("fill count above depth");
   property p_fill_rd; s_taken ##0 (read && address[7:2] == 6'h04) |=> readdata[7:0] == {1'b0, eng_fill}; endproperty
   a_fill_rd: assert property (p_fill_rd) else $error("fill register differs from count");
   property p_upper; readdata[31:8] == 24'h000000; endproperty
   a_upper: assert property (p_upper) else $error("upper read data not zero");
endmodule : shf_queue_chk
bind shf_queue_top shf_queue_chk #(.DEPTH(DEPTH)) i_shf_queue_chk (.clk, .rst_b, .address, .read,
   .write, .byteenable, .readdata, .waitrequest, .eng_push, .eng_pop, .eng_ack, .eng_fill);
`default_nettype wire

//--- verif/shf_host_model.sv
// Host bus master model for the queue registers
`timescale 1ns/10ps
`default_nettype none
module shf_host_model (
   input wire logic clk,
   input wire logic waitrequest,
   input wire logic [31:0] readdata,
   output logic [7:0] address,
   output logic read,
   output logic write,
   output logic [31:0] writedata,
   output logic [3:0] byteenable,
   output logic hang
);
   import shf_pkg::*;
   initial begin
      address = 8'h00;
      read = 1'b0;
      write = 1'b0;
      writedata = 32'h00000000;
      byteenable = 4'hf;
      hang = 1'b0;
   end
   task automatic wait_ack;
      int n;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (waitrequest && n < 50);
      if (waitrequest) hang <= 1'b1;
   endtask : wait_ack
   // no data access in engine phases
   task automatic wr(input logic [5:0] idx, input shf_byte_t d);
      address <= {idx, 2'b00};
      writedata <= {24'h000000, d};
      write <= 1'b1;
      wait_ack();
      write <= 1'b0;
      @(posedge clk);
   endtask : wr
   task automatic rd(input logic [5:0] idx, output shf_byte_t d);
      address <= {idx, 2'b00};
      read <= 1'b1;
      wait_ack();
      d = readdata[7:0];
      read <= 1'b0;
      @(posedge clk);
   endtask : rd
endmodule : shf_host_model
`default_nettype wire

//--- verif/tb_top.sv
// Self-checking bench for the shared queue
`timescale 1ns/10ps
`default_nettype none
module tb_top;
   import shf_pkg::*;
   localparam int DEPTH = 64;
   logic clk, rst_b, read, write, waitrequest, eng_push, eng_pop, eng_ack, host_irq, hang;
   logic [7:0] address;
   logic [31:0] writedata, readdata;
   logic [3:0] byteenable;
   shf_byte_t eng_push_data, eng_pop_data, d;
   shf_count_t eng_fill;
   int num_errors = 0;
   int num_checks = 0;
   shf_queue_top #(.DEPTH(DEPTH)) i_shf_queue_top (.clk, .rst_b, .address, .read, .write,
      .writedata, .byteenable, .readdata, .waitrequest, .eng_push, .eng_push_data, .eng_pop,
      .eng_pop_data, .eng_ack, .eng_fill, .host_irq);
   shf_host_model i_shf_host_model (.clk, .waitrequest, .readdata, .address, .read, .write,
      .writedata, .byteenable, .hang);
   task automatic chk(input shf_byte_t got, input shf_byte_t exp);
      num_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic chk_bit(input logic got, input logic exp);
      num_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk_bit
   task automatic rchk(input logic [5:0] idx, input shf_byte_t exp);
      i_shf_host_model.rd(idx, d);
      chk(d, exp);
   endtask : rchk
   function automatic shf_byte_t exp_st(input int c, input int thr, input logic irq);
      return {4'h0, irq, 1'b0, (DEPTH - c) <= thr, c <= thr};
   endfunction : exp_st
   task automatic eng_op(input logic push, input shf_byte_t pd, input logic pop);
      int n;
      eng_push <= push;
      eng_push_data <= pd;
      eng_pop <= pop;
      @(posedge clk);
      eng_push <= 1'b0;
      eng_pop <= 1'b0;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (!eng_ack && n < 50);
      chk_bit(eng_ack, 1'b1);
      d = eng_pop_data;
   endtask : eng_op
   task automatic t_reset;
      rchk(6'h29, 8'h08);
      rchk(6'h04, 8'h00);
      rchk(6'h03, exp_st(0, 8, 1'b0));
      rchk(6'h0a, 8'h00);
      rchk(6'h07, 8'h01);
      rchk(6'h3f, 8'h00);
      $display("t_reset done");
   endtask : t_reset
   task automatic t_fill;
      for (int i = 1; i <= DEPTH; i++) begin
         i_shf_host_model.wr(6'h02, 8'(i));
         rchk(6'h03, exp_st(i, 8, 1'b0));
      end
      rchk(6'h04, 8'h40);
      i_shf_host_model.wr(6'h02, 8'hee);
      rchk(6'h0a, 8'h10);
      for (int i = 1; i <= DEPTH; i++) rchk(6'h02, 8'(i));
      rchk(6'h02, 8'h00);
      rchk(6'h04, 8'h00);
      $display("t_fill done");
   endtask : t_fill
   task automatic t_purge;
      i_shf_host_model.wr(6'h02, 8'h11);
      i_shf_host_model.wr(6'h09, 8'h01);
      rchk(6'h04, 8'h00);
      rchk(6'h0a, 8'h00);
      i_shf_host_model.wr(6'h02, 8'h5a);
      rchk(6'h02, 8'h5a);
      $display("t_purge done");
   endtask : t_purge
   task automatic t_irq;
      i_shf_host_model.wr(6'h07, 8'h02);
      rchk(6'h07, 8'h01);
      i_shf_host_model.wr(6'h06, 8'h82);
      rchk(6'h06, 8'h02);
      chk_bit(host_irq, 1'b0);
      i_shf_host_model.wr(6'h06, 8'h81);
      rchk(6'h06, 8'h03);
      rchk(6'h03, exp_st(0, 8, 1'b1));
      chk_bit(host_irq, 1'b1);
      i_shf_host_model.wr(6'h06, 8'h03);
      rchk(6'h06, 8'h00);
      rchk(6'h03, exp_st(0, 8, 1'b0));
      chk_bit(host_irq, 1'b0);
      $display("t_irq done");
   endtask : t_irq
   task automatic t_eng;
      eng_op(1'b1, 8'hc3, 1'b0);
      eng_op(1'b1, 8'h3c, 1'b0);
      rchk(6'h04, 8'h02);
      rchk(6'h02, 8'hc3);
      i_shf_host_model.wr(6'h02, 8'h77);
      eng_op(1'b0, 8'h00, 1'b1);
      chk(d, 8'h3c);
      eng_op(1'b1, 8'h99, 1'b1);
      chk(d, 8'h77);
      i_shf_host_model.wr(6'h29, 8'h3f);
      rchk(6'h29, 8'h3f);
      rchk(6'h03, exp_st(1, 63, 1'b0));
      chk({1'b0, eng_fill}, 8'h01);
      $display("t_eng done");
   endtask : t_eng
   task automatic results;
      $display("checks %0d mismatches %0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : results
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   always @(posedge hang) begin
      num_errors++;
      results();
   end
   initial begin
      rst_b = 1'b0;
      eng_push = 1'b0;
      eng_push_data = 8'h00;
      eng_pop = 1'b0;
      repeat (8) @(posedge clk);
      rst_b <= 1'b1;
      @(posedge clk);
      t_reset();
      t_fill();
      t_purge();
      t_irq();
      t_eng();
      results();
   end
endmodule : tb_top
`default_nettype wire
